// file: rtl/apf_defs.vh
// Constants for the async packet FIFO framer: offsets, fields, codes, sizes.
// Assumes inclusion by plain name from files under rtl/.
`ifndef APF_DEFS_VH
`define APF_DEFS_VH
`define APF_ADDR_W 8
`define APF_OFS_STATUS 8'h1c
`define APF_OFS_TX_FIRST 8'h70
`define APF_OFS_DATA_PORT 8'h74
`define APF_OFS_TX_LAST 8'h7c
`define APF_OFS_RX_PUSH 8'h80
`define APF_OFS_CTRL 8'h84
`define APF_RX_DEPTH 39
`define APF_RX_AW 6
`define APF_TX_DEPTH 24
`define APF_TX_AW 5
`define APF_ST_BOUNDARY 28
`define APF_ST_RX_AEMPTY 27
`define APF_ST_RX_EMPTY 26
`define APF_ST_RX_FOUR 25
`define APF_ST_TX_FULL 23
`define APF_ST_TX_AFULL 22
`define APF_ST_TX_FOUR 21
`define APF_ST_TX_AEMPTY 20
`define APF_ST_TX_EMPTY 19
`define APF_ST_TC_ERR 18
`define APF_ST_SEQ_ERR 17
`define APF_CTRL_CLR_TX 0
`define APF_CTRL_CLR_RX 1
`define APF_CTRL_CLR_ERR 2
`define APF_F_IMM 18
`define APF_F_SPD_HI 17
`define APF_F_SPD_LO 16
`define APF_F_PRI_HI 3
`define APF_F_PRI_LO 0
`define APF_F_TC_HI 7
`define APF_F_TC_LO 4
`define APF_ACK_OVERFLOW 4'h4
`define APF_ACK_DATA_ERR 4'hd
`define APF_SPD_RESERVED 2'h3
`define APF_TC_MASK 16'h4af7
`endif

// file: rtl/apf_fifo.v
// Quadlet FIFO with first/last packet marks and a level count.
// Assumes one clock; caller never pushes when full.
`timescale 1ns/1ps
module apf_fifo #(
	parameter DEPTH = 39,
	parameter AW = 6
)(
	input wire core_clk_i,
	input wire rst_n_i,
	input wire clear_i,
	input wire push_i,
	input wire [33:0] push_data_i,
	input wire pop_i,
	output wire [33:0] head_o,
	output wire [AW:0] count_o
);
	reg [33:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire do_push;
	wire do_pop;
	assign do_pop = pop_i && (cnt_reg != {(AW+1){1'b0}});
	assign do_push = push_i && (cnt_reg != DEPTH[AW:0]);
	assign head_o = mem[rd_reg];
	assign count_o = cnt_reg;
	always @(posedge core_clk_i)
	begin
		if (do_push)
			mem[wr_reg] <= push_data_i;
	end
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else if (clear_i)
		begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			if (do_pop)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			if (do_push && !do_pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (do_pop && !do_push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // apf_fifo

// file: rtl/apf_framer.v
// Async packet framer: transmit queue with header checks, receive queue
// with status trailer, host register port. Link side is plain ports.
// Behaviour
// - Boundary flag high at first received quadlet
// - Boundary flag only at first/last quadlet
// - Four-available permits four blind reads
// - Almost-empty when exactly one quadlet remains
// - Empty read pops nothing, repeats last
// - Trailer quadlet carries ack code always
// - Ack 04h marks possible overflow
// - Ack 0Dh marks CRC or length error
// - Formats: no-data, quadlet, block, unformatted
// - Quadlet and block formats carry listed types
// - Imm packet sent right after ack
// - Speed codes 100/200/400, 11 reserved
// - Retry codes 1, X, A, B
// - Nonzero priority selects priority arbitration
// - No payload when data length zero
// - Payload bytes most significant first
// - Only listed transaction codes transmitted
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "apf_defs.vh"
module apf_framer (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [7:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [31:0] rdata_o,
	input wire rx_push_i,
	input wire [31:0] rx_quadlet_i,
	input wire rx_first_i,
	input wire rx_last_i,
	input wire [3:0] rx_ack_i,
	input wire rx_overflowed_i,
	input wire rx_data_err_i,
	output reg rx_ready_o,
	input wire tx_pop_i,
	input wire ack_sent_i,
	output reg [31:0] tx_quadlet_o,
	output reg tx_first_o,
	output reg tx_last_o,
	output reg tx_valid_o,
	output reg tx_req_o,
	output reg tx_immediate_o,
	output reg tx_priority_arb_o,
	output reg [1:0] tx_speed_o,
	output reg bad_transaction_code_error_o
);
	wire [33:0] rx_head;
	wire [6:0] rx_count;
	wire [33:0] tx_head;
	wire [5:0] tx_count;
	reg [31:0] last_read_reg;
	reg tc_err_reg;
	reg seq_err_reg;
	reg in_pkt_reg;
	reg ctrl_clr_tx_reg;
	reg ctrl_clr_rx_reg;
	reg trailer_pend_reg;
	reg [3:0] trailer_ack_reg;
	reg imm_pend_reg;
	reg [31:0] rdata_next;
	wire rx_empty;
	wire rx_pop;
	wire rx_link_push;
	wire [33:0] rx_push_word;
	wire [3:0] ack_code;
	wire tx_first_wr;
	wire tx_mid_wr;
	wire tx_last_wr;
	wire tx_push;
	wire tx_full;
	wire [3:0] tcode;
	wire [15:0] tc_shift;
	wire tc_ok;
	wire hdr_ok;
	wire tx_blocked;
	wire [31:0] status_word;

	// Receive queue
	assign rx_empty = (rx_count == 7'h00);
	assign rx_pop = rd_i && (addr_i == `APF_OFS_DATA_PORT) && !rx_empty;
	assign ack_code = rx_overflowed_i ? `APF_ACK_OVERFLOW :
		(rx_data_err_i ? `APF_ACK_DATA_ERR : rx_ack_i);
	// Trailer slot is taken right after the last link quadlet
	assign rx_link_push = rx_push_i && !trailer_pend_reg;
	assign rx_push_word = trailer_pend_reg ?
		{1'b0, 1'b1, 28'h0000000, trailer_ack_reg} :
		{rx_first_i, 1'b0, rx_quadlet_i};

	apf_fifo #(
		.DEPTH(`APF_RX_DEPTH),
		.AW(`APF_RX_AW)
	) u_rx_fifo (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(ctrl_clr_rx_reg),
		.push_i(rx_link_push || trailer_pend_reg),
		.push_data_i(rx_push_word),
		.pop_i(rx_pop),
		.head_o(rx_head),
		.count_o(rx_count)
	);

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			trailer_pend_reg <= 1'b0;
			trailer_ack_reg <= 4'h0;
			rx_ready_o <= 1'b0;
			last_read_reg <= 32'h00000000;
		end
		else
		begin
			if (trailer_pend_reg)
				trailer_pend_reg <= 1'b0;
			else if (rx_link_push && rx_last_i)
			begin
				trailer_pend_reg <= 1'b1;
				trailer_ack_reg <= ack_code;
			end
			// Two spare slots keep room for a quadlet plus trailer
			rx_ready_o <= (rx_count < 7'd37) && !(rx_push_i && rx_last_i);
			if (rx_pop)
				last_read_reg <= rx_head[31:0];
		end
	end

	// Transmit queue: first/mid/last writes build one packet
	assign tx_first_wr = wr_i && (addr_i == `APF_OFS_TX_FIRST);
	assign tx_mid_wr = wr_i && (addr_i == `APF_OFS_DATA_PORT);
	assign tx_last_wr = wr_i && (addr_i == `APF_OFS_TX_LAST);
	assign tx_full = (tx_count == 6'd24);
	assign tcode = wdata_i[`APF_F_TC_HI:`APF_F_TC_LO];
	assign tc_shift = `APF_TC_MASK >> tcode;
	assign tc_ok = tc_shift[0];
	assign hdr_ok = tc_ok && (wdata_i[`APF_F_SPD_HI:`APF_F_SPD_LO] != `APF_SPD_RESERVED);
	assign tx_blocked = tc_err_reg || seq_err_reg;
	// Bad headers never enter the queue
	assign tx_push = ((tx_first_wr && hdr_ok) || ((tx_mid_wr || tx_last_wr) && in_pkt_reg))
		&& !tx_full && !tx_blocked;

	apf_fifo #(
		.DEPTH(`APF_TX_DEPTH),
		.AW(`APF_TX_AW)
	) u_tx_fifo (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(ctrl_clr_tx_reg),
		.push_i(tx_push),
		.push_data_i({tx_first_wr, tx_last_wr, wdata_i}),
		.pop_i(tx_pop_i && tx_valid_o),
		.head_o(tx_head),
		.count_o(tx_count)
	);

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tc_err_reg <= 1'b0;
			seq_err_reg <= 1'b0;
			in_pkt_reg <= 1'b0;
			ctrl_clr_tx_reg <= 1'b0;
			ctrl_clr_rx_reg <= 1'b0;
			imm_pend_reg <= 1'b0;
		end
		else
		begin
			ctrl_clr_tx_reg <= wr_i && (addr_i == `APF_OFS_CTRL) && wdata_i[`APF_CTRL_CLR_TX];
			ctrl_clr_rx_reg <= wr_i && (addr_i == `APF_OFS_CTRL) && wdata_i[`APF_CTRL_CLR_RX];
			if (tx_first_wr && !tx_blocked && !tx_full)
			begin
				in_pkt_reg <= 1'b1;
				if (!hdr_ok)
					tc_err_reg <= 1'b1;
			end
			else if (tx_last_wr)
				in_pkt_reg <= 1'b0;
			else if (tx_mid_wr && !in_pkt_reg)
				seq_err_reg <= 1'b1;
			if (tx_last_wr && !in_pkt_reg)
				seq_err_reg <= 1'b1;
			if (wr_i && addr_i == `APF_OFS_CTRL && wdata_i[`APF_CTRL_CLR_ERR])
			begin
				tc_err_reg <= tx_first_wr ? tc_err_reg : 1'b0;
				seq_err_reg <= 1'b0;
			end
			if (ack_sent_i)
				imm_pend_reg <= 1'b1;
			else if (tx_pop_i && tx_valid_o && tx_head[33])
				imm_pend_reg <= 1'b0;
		end
	end

	// Link-facing transmit outputs, all registered
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_quadlet_o <= 32'h00000000;
			tx_first_o <= 1'b0;
			tx_last_o <= 1'b0;
			tx_valid_o <= 1'b0;
			tx_req_o <= 1'b0;
			tx_immediate_o <= 1'b0;
			tx_priority_arb_o <= 1'b0;
			tx_speed_o <= 2'h0;
			bad_transaction_code_error_o <= 1'b0;
		end
		else
		begin
			tx_quadlet_o <= tx_head[31:0];
			tx_first_o <= tx_head[33];
			tx_last_o <= tx_head[32];
			tx_valid_o <= (tx_count != 6'd0) && !tx_blocked && !(tx_pop_i && tx_valid_o);
			tx_req_o <= (tx_count != 6'd0) && !tx_blocked && tx_head[33];
			tx_immediate_o <= tx_head[33] && tx_head[`APF_F_IMM] && imm_pend_reg;
			tx_priority_arb_o <= tx_head[33] &&
				(tx_head[`APF_F_PRI_HI:`APF_F_PRI_LO] != 4'h0);
			tx_speed_o <= tx_head[`APF_F_SPD_HI:`APF_F_SPD_LO];
			bad_transaction_code_error_o <= tc_err_reg;
		end
	end

	// Status word and read mux
	assign status_word = {3'h0,
		!rx_empty && (rx_head[33] || rx_head[32]),
		rx_count == 7'd1,
		rx_empty,
		rx_count >= 7'd4,
		1'b0,
		tx_full,
		tx_count == 6'd23,
		tx_count <= 6'd20,
		tx_count == 6'd1,
		tx_count == 6'd0,
		tc_err_reg,
		seq_err_reg,
		17'h00000};

	always @*
	begin
		case (addr_i)
			`APF_OFS_STATUS: rdata_next = status_word;
			`APF_OFS_DATA_PORT: rdata_next = rx_empty ? last_read_reg : rx_head[31:0];
			`APF_OFS_CTRL: rdata_next = {29'h0, tx_blocked, ctrl_clr_rx_reg, ctrl_clr_tx_reg};
			default: rdata_next = 32'h00000000;
		endcase
	end

	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_o <= 32'h00000000;
		else if (rd_i)
			rdata_o <= rdata_next;
		else
			rdata_o <= 32'h00000000;
	end
endmodule // apf_framer

// file: test/apf_framer_assertions.sv
// Checker on the framer's register and transmit ports.
// Assumes one clock; bound into apf_framer.
`timescale 1ns/1ps
`include "apf_defs.vh"
module apf_framer_chk (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [7:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [31:0] rdata_o,
	input wire rx_push_i,
	input wire rx_last_i,
	input wire rx_ready_o,
	input wire [31:0] tx_quadlet_o,
	input wire tx_first_o,
	input wire tx_last_o,
	input wire tx_valid_o,
	input wire tx_req_o,
	input wire tx_immediate_o,
	input wire tx_priority_arb_o,
	input wire [1:0] tx_speed_o,
	input wire bad_transaction_code_error_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire st = rd_i && addr_i == `APF_OFS_STATUS;
	wire hd = tx_req_o && tx_valid_o;
	wire clr = wr_i && addr_i == `APF_OFS_CTRL && wdata_i[2];
	a_empty_no_marks: assert property
		(st |=> !(rdata_o[26] && (rdata_o[28] || rdata_o[27] || rdata_o[25]))) else $error("flags");
	a_one_not_four: assert property
		(st |=> !(rdata_o[27] && rdata_o[25])) else $error("aempty");
	a_head_speed: assert property
		(hd |-> tx_speed_o == tx_quadlet_o[17:16]) else $error("speed");
	a_head_imm: assert property
		(hd |-> tx_immediate_o == tx_quadlet_o[18]) else $error("imm");
	a_head_prio: assert property
		(hd |-> tx_priority_arb_o == (tx_quadlet_o[3:0] != 4'h0)) else $error("prio");
	a_tcode_legal: assert property
		(tx_valid_o && tx_first_o |-> ((`APF_TC_MASK >> tx_quadlet_o[7:4]) & 16'h1) != 16'h0)
		else $error("tcode");
	a_err_sticky: assert property
		(bad_transaction_code_error_o && !clr && !$past(clr) |=> bad_transaction_code_error_o)
		else $error("sticky");
	a_err_status: assert property
		(st |=> rdata_o[18] == $past(bad_transaction_code_error_o)) else $error("errbit");
	a_tail_not_head: assert property
		(tx_valid_o && tx_last_o |-> !tx_first_o) else $error("tail");
	a_ready_after_last: assert property
		(rx_push_i && rx_last_i |=> !rx_ready_o) else $error("ready");
endmodule // apf_framer_chk
bind apf_framer apf_framer_chk u_chk (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .rx_push_i, .rx_last_i, .rx_ready_o, .tx_quadlet_o, .tx_first_o, .tx_last_o,
	.tx_valid_o, .tx_req_o, .tx_immediate_o, .tx_priority_arb_o, .tx_speed_o,
	.bad_transaction_code_error_o);

// file: test/apf_link_model.sv
// Link side: pushes received quadlets, drains transmit queue.
// Assumes the bench calls send and reads got.
`timescale 1ns/1ps
module apf_link_model (
	input wire clk_i,
	input wire ready_i,
	input wire valid_i,
	input wire [31:0] q_i,
	output reg push_o = 1'b0,
	output reg [31:0] q_o = 32'h0,
	output reg first_o = 1'b0,
	output reg last_o = 1'b0,
	output reg [3:0] ack_o = 4'h0,
	output reg ovf_o = 1'b0,
	output reg derr_o = 1'b0,
	output reg pop_o = 1'b0,
	output reg acks_o = 1'b0
);
	logic [31:0] got [$];
	int err = 0;
	// One pop per valid; ack pulse after each packet end
	always @(posedge clk_i)
	begin
		pop_o <= valid_i && !pop_o;
		acks_o <= push_o && last_o;
		if (valid_i && !pop_o)
			got.push_back(q_i);
	end
	// Ack code and faults ride with the last quadlet
	task automatic send(input logic [31:0] q, input logic f, l, input logic [3:0] a,
		input logic o, d);
		int i;
		@(posedge clk_i);
		for (i = 0; i < 50 && !ready_i; i++)
			@(posedge clk_i);
		if (!ready_i)
			err++;
		{q_o, first_o, last_o, ack_o, ovf_o, derr_o} <= {q, f, l, a, o, d};
		push_o <= 1'b1;
		@(posedge clk_i);
		push_o <= 1'b0;
	endtask
endmodule // apf_link_model

// file: test/apf_framer_test.sv
// Bench: register reads and writes against the framer and link model.
// Assumes design files under rtl/.
`timescale 1ns/1ps
`include "apf_defs.vh"
module apf_framer_test;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] addr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, rx_quadlet_i, tx_quadlet_o;
	logic rx_push_i, rx_first_i, rx_last_i, rx_overflowed_i, rx_data_err_i, rx_ready_o;
	logic tx_pop_i, ack_sent_i, tx_first_o, tx_last_o, tx_valid_o, tx_req_o;
	logic tx_immediate_o, tx_priority_arb_o, bad_transaction_code_error_o;
	logic [3:0] rx_ack_i;
	logic [1:0] tx_speed_o;
	logic [31:0] pk [4] = '{32'h00050003, 32'hffc1ffff, 32'hf000000c, 32'h12345678};
	int fails = 0, compares = 0, i;
	always #20 core_clk_i = ~core_clk_i;
	apf_framer dut (.*);
	apf_link_model link (.clk_i(core_clk_i), .ready_i(rx_ready_o), .valid_i(tx_valid_o),
		.q_i(tx_quadlet_o), .push_o(rx_push_i), .q_o(rx_quadlet_i), .first_o(rx_first_i),
		.last_o(rx_last_i), .ack_o(rx_ack_i), .ovf_o(rx_overflowed_i), .derr_o(rx_data_err_i),
		.pop_o(tx_pop_i), .acks_o(ack_sent_i));
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		{addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, m = 32'hffffffff);
		@(posedge core_clk_i);
		{addr_i, rd_i} <= {a, 1'b1};
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(rdata_o & m, e);
	endtask
	initial
	begin
		#2000000;
		fails++;
		end_sim;
	end
	initial
	begin
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rdc(`APF_OFS_STATUS, 32'h04280000);
		rdc(8'h40, 32'h0);
		for (i = 0; i < 4; i++)
			link.send(pk[i] ^ 32'hffc00000, i == 0, i == 3, 4'h1, 1'b0, 1'b0);
		repeat (3) @(posedge core_clk_i);
		rdc(`APF_OFS_STATUS, 32'h12280000);
		for (i = 0; i < 4; i++)
			rdc(`APF_OFS_DATA_PORT, pk[i] ^ 32'hffc00000);
		rdc(`APF_OFS_STATUS, 32'h18280000);
		rdc(`APF_OFS_DATA_PORT, 32'h1);
		rdc(`APF_OFS_STATUS, 32'h04280000);
		rdc(`APF_OFS_DATA_PORT, 32'h1);
		$display("rx test done");
		for (i = 0; i < 4; i++)
			wrr(i == 0 ? `APF_OFS_TX_FIRST : i == 3 ? `APF_OFS_TX_LAST : `APF_OFS_DATA_PORT, pk[i]);
		for (i = 0; i < 3; i++)
		begin
			link.send(32'hf0f00000 + i, 1'b1, 1'b0, 4'h2, i == 1, i == 2);
			link.send(32'hf0f00010 + i, 1'b0, 1'b1, 4'h2, i == 1, i == 2);
			repeat (3) @(posedge core_clk_i);
			rdc(`APF_OFS_DATA_PORT, 32'hf0f00000 + i);
			rdc(`APF_OFS_DATA_PORT, 32'hf0f00010 + i);
			rdc(`APF_OFS_DATA_PORT, i == 1 ? 32'h4 : i == 2 ? 32'hd : 32'h2);
		end
		chk(link.got.size(), 32'h4);
		for (i = 0; i < 4; i++)
			chk(link.got[i], pk[i]);
		wrr(`APF_OFS_TX_FIRST, 32'h00000010);
		wrr(`APF_OFS_DATA_PORT, 32'hffc1ffff);
		wrr(`APF_OFS_DATA_PORT, 32'hf0000000);
		wrr(`APF_OFS_DATA_PORT, 32'h00040000);
		wrr(`APF_OFS_TX_LAST, 32'haabbccdd);
		repeat (30) @(posedge core_clk_i);
		chk(link.got.size(), 32'h9);
		chk(link.got[4], 32'h00000010);
		chk(link.got[7], 32'h00040000);
		chk(link.got[8], 32'haabbccdd);
		$display("tx and ack test done");
		for (i = 0; i < 17; i++)
		begin
			wrr(`APF_OFS_TX_FIRST, i == 16 ? 32'h30000 : i << 4);
			wrr(`APF_OFS_TX_LAST, 32'h0);
			rdc(`APF_OFS_STATUS, i < 16 && ((`APF_TC_MASK >> i) & 1) ? 0 : 32'h40000,
				32'h40000);
			wrr(`APF_OFS_CTRL, 32'h5);
		end
		chk(link.err, 32'h0);
		$display("tcode test done");
		end_sim;
	end
endmodule // apf_framer_test
